/* File: test/clock_board_model.sv */
// Board-side partner: reference source and the feedback trace.
// Assumes the design samples the reference on rising pclk edges.
`default_nettype none

module clock_board_model #(
  parameter int REF_HALF = 4
) (
  input wire logic pclk,
  input wire logic fed_back_clock,
  input wire logic outs_oe_n,
  output logic [1:0] reference_clock_pair,
  output logic loop_feedback_input
);
  timeunit 1ns;
  timeprecision 1ps;

  int phase = 0;
  logic ref_level = 1'b0;
  logic float_level = 1'b0;

  // ==========================================================================
  // Free-running reference, fixed rate and phase
  always @(posedge pclk) begin
    float_level <= ~float_level;
    if (phase == REF_HALF - 1) begin
      phase <= 0;
      ref_level <= ~ref_level;
    end else begin
      phase <= phase + 1;
    end
  end

  assign reference_clock_pair = {ref_level, ~ref_level};
  // One output wired back; an undriven trace wanders while outputs float
  assign loop_feedback_input = outs_oe_n ? float_level : fed_back_clock;

endmodule : clock_board_model

`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the clock fanout control: pins and APB.
// Assumes the board model supplies the reference and feedback trace.
`default_nettype none

module testbench
  import clock_fanout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int REF_HALF = 4;
  localparam int WIN = 640;
  typedef struct {
    logic oe_n;
    logic [1:0] sel;
    logic exp_oe_n;
    logic [3:0] quarter;
  } row_type;
  row_type rows [5] = '{'{1'b0, 2'h0, 1'b0, 4'h0}, '{1'b0, 2'h1, 1'b0, 4'h1},
    '{1'b0, 2'h2, 1'b0, 4'h3}, '{1'b0, 2'h3, 1'b0, 4'h7},
    '{1'b1, 2'h3, 1'b1, 4'h7}};

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, fb;
  logic [1:0] ref_pair;
  logic clr_n = 1'b1;
  logic oe_n = 1'b0;
  logic test = 1'b1;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b0;
  logic [2:0] out1, out2, out3, out4;
  logic outs_oe_n;
  wire logic [3:0] lead;
  status_type st;
  int error_cnt = 0;
  int total_checks = 0;
  int hi, lo, c1, c4;

  assign lead = {out4[0], out3[0], out2[0], out1[0]};

  // ==========================================================================
  // Clock, design and board
  always #25 pclk = ~pclk;

  clock_fanout_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_clock_pair(ref_pair), .loop_feedback_input(fb),
    .quarter_divider_clear_n(clr_n), .output_enable_n(oe_n),
    .test_mode(test), .bank_rate_select_hi(sel_hi),
    .bank_rate_select_lo(sel_lo), .bank_one_clock_outs(out1),
    .bank_two_clock_outs(out2), .bank_three_clock_outs(out3),
    .bank_four_clock_outs(out4), .clock_outs_oe_n(outs_oe_n));

  clock_board_model #(.REF_HALF(REF_HALF)) i_board (.pclk(pclk),
    .fed_back_clock(out4[0]), .outs_oe_n(outs_oe_n),
    .reference_clock_pair(ref_pair), .loop_feedback_input(fb));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("apb answer", n < 50, 1'b1);
  endtask : apb

  task automatic read_status();
    apb(1'b0, STATUS_OFFSET, 32'h0);
    st = status_type'(rd[3:0]);
  endtask : read_status

  // Wait for lead bit b to reach level v anew
  task automatic wait_to(input int b, input logic v);
    int n;
    n = 0;
    while (lead[b] === v && n < 200) begin
      @(negedge pclk);
      n++;
    end
    while (lead[b] !== v && n < 200) begin
      @(negedge pclk);
      n++;
    end
  endtask : wait_to

  task automatic measure(input int b);
    wait_to(b, 1'b1);
    hi = 0;
    lo = 0;
    while (lead[b] === 1'b1 && hi < 100) begin
      @(negedge pclk);
      hi++;
    end
    while (lead[b] === 1'b0 && lo < 100) begin
      @(negedge pclk);
      lo++;
    end
  endtask : measure

  task automatic count_rises();
    logic [3:0] prev;
    c1 = 0;
    c4 = 0;
    prev = lead;
    repeat (WIN) begin
      @(negedge pclk);
      c1 += int'(lead[0] && !prev[0]);
      c4 += int'(lead[3] && !prev[3]);
      prev = lead;
    end
  endtask : count_rises

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    check("reset oe", outs_oe_n, 1'b1);
    check("reset outs", {out1, out2, out3, out4}, 12'h000);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl reset", rd, {24'h0, PERIOD_RESET});
    apb(1'b1, CTRL_OFFSET, 32'h0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl floor", rd, {24'h0, PERIOD_MIN});
    apb(1'b1, CTRL_OFFSET, {24'h0, PERIOD_RESET});
    apb(1'b1, STATUS_OFFSET, 32'h0000_00ff);
    check("status write err", err, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    // Bypass mode table: every select code, both enable levels
    foreach (rows[i]) begin
      @(posedge pclk);
      oe_n <= rows[i].oe_n;
      {sel_hi, sel_lo} <= rows[i].sel;
      repeat (100) @(posedge pclk);
      check("outs oe", outs_oe_n, rows[i].exp_oe_n);
      read_status();
      check("bypass", st.bypass, 1'b1);
      check("driven", st.outputs_driven, !rows[i].exp_oe_n);
      for (int b = 0; b < 4; b++) begin
        measure(b);
        check("high", hi, (rows[i].quarter[b] ? 4 : 2) * REF_HALF);
        check("low", lo, (rows[i].quarter[b] ? 4 : 2) * REF_HALF);
      end
    end
    // Clear edge realigns the quarter banks; held level does nothing
    @(posedge pclk);
    oe_n <= 1'b0;
    wait_to(0, 1'b0);
    @(posedge pclk);
    clr_n <= 1'b0;
    wait_to(3, 1'b0);
    check("forced low", lead[0], 1'b0);
    wait_to(3, 1'b0);
    check("resumed", lead[0], 1'b1);
    measure(3);
    check("half no runt high", hi, 2 * REF_HALF);
    check("half no runt low", lo, 2 * REF_HALF);
    measure(0);
    check("level ignored", hi, 4 * REF_HALF);
    @(posedge pclk);
    clr_n <= 1'b1;
    // Loop path: lock wait, rates, relock triggers
    test <= 1'b0;
    {sel_hi, sel_lo} <= 2'b01;
    repeat (20) @(posedge pclk);
    read_status();
    check("bypass off", st.bypass, 1'b0);
    check("unlocked", st.locked, 1'b0);
    repeat (1100) @(posedge pclk);
    read_status();
    check("locked", st.locked, 1'b1);
    count_rises();
    check("half rate", c4, WIN / (2 * REF_HALF));
    check("quarter rate", c1, WIN / (4 * REF_HALF));
    // Aligned loop: feedback rises in the cycle that the reference rises
    wait_to(3, 1'b0);
    hi = 0;
    while (lead[3] !== 1'b1 && hi < 20) begin
      lo = int'(ref_pair[1]);
      @(negedge pclk);
      hi++;
    end
    check("ref low before", lo, 0);
    check("ref at fb rise", ref_pair[1], 1'b1);
    @(posedge pclk);
    oe_n <= 1'b1;
    repeat (20) @(posedge pclk);
    read_status();
    check("floated", st.outputs_driven, 1'b0);
    oe_n <= 1'b0;
    repeat (20) @(posedge pclk);
    read_status();
    check("relock oe", st.locked, 1'b0);
    repeat (1100) @(posedge pclk);
    read_status();
    check("locked again", st.locked, 1'b1);
    {sel_hi, sel_lo} <= 2'b11;
    repeat (20) @(posedge pclk);
    read_status();
    check("relock sel", st.locked, 1'b0);
    finish_test();
  end

endmodule : testbench

`default_nettype wire

/* File: verilog/clock_fanout_control.sv */
// Output-side control of the PLL clock fanout: VCO model, dividers, banks.
// Assumes pins synchronous to pclk and software on an APB slave port.
`default_nettype none

module clock_fanout_control
  import clock_fanout_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] reference_clock_pair,
  input wire logic loop_feedback_input,
  input wire logic quarter_divider_clear_n,
  input wire logic output_enable_n,
  input wire logic test_mode,
  input wire logic bank_rate_select_hi,
  input wire logic bank_rate_select_lo,
  output logic [2:0] bank_one_clock_outs,
  output logic [2:0] bank_two_clock_outs,
  output logic [2:0] bank_three_clock_outs,
  output logic [2:0] bank_four_clock_outs,
  output logic clock_outs_oe_n
);

  // ==========================================================================
  // Pin history and edge detection
  logic ref_prev, fb_prev, oe_prev, test_prev, clear_prev;
  logic [1:0] sel_prev;
  logic ref_now, ref_rise, fb_rise, clear_fall, restart;
  logic [1:0] sel_count;

  assign sel_count = {bank_rate_select_hi, bank_rate_select_lo};
  assign ref_now = reference_clock_pair[1] & ~reference_clock_pair[0];
  assign ref_rise = ref_now & ~ref_prev;
  assign fb_rise = loop_feedback_input & ~fb_prev;
  assign clear_fall = clear_prev & ~quarter_divider_clear_n;
  // Events that disturb the loop and restart the stabilisation wait
  assign restart = (oe_prev & ~output_enable_n) | (sel_prev != sel_count)
                 | (test_prev & ~test_mode);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev <= 1'b0;
      fb_prev <= 1'b0;
      oe_prev <= 1'b1;
      test_prev <= 1'b0;
      clear_prev <= 1'b0; // A clear strapped low gives no edge
      sel_prev <= 2'h0;
    end else begin
      ref_prev <= ref_now;
      fb_prev <= loop_feedback_input;
      oe_prev <= output_enable_n;
      test_prev <= test_mode;
      clear_prev <= quarter_divider_clear_n;
      sel_prev <= sel_count;
    end
  end

  // ==========================================================================
  // APB slave with one wait state
  logic [PERIOD_WIDTH-1:0] half_period, next_half_period;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic mapped;
  status_type status;

  assign mapped = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET);

  // Decode, read mux and control write
  always_comb begin
    next_half_period = half_period;
    next_pready = psel & penable & ~pready;
    next_prdata = 32'h0;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pslverr = ~mapped;
      if (!pwrite && paddr == CTRL_OFFSET) begin
        next_prdata = {24'h0, half_period};
      end else if (!pwrite && paddr == STATUS_OFFSET) begin
        next_prdata = {28'h0, status};
      end
    end
    if (psel && penable && pready && pwrite && paddr == CTRL_OFFSET) begin
      next_half_period = (pwdata[7:0] < PERIOD_MIN) ? PERIOD_MIN
                                                     : pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_period <= PERIOD_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      half_period <= next_half_period;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================================
  // VCO model, phase trim and lock timer
  logic [PERIOD_WIDTH-1:0] vco_count, next_vco_count;
  logic [STAB_WIDTH-1:0] stab_count, next_stab_count;
  logic fb_seen, next_fb_seen;
  logic feedback_early, next_feedback_early;
  logic locked;
  logic vco_expire, vco_tick;
  trim_type trim, next_trim;

  assign vco_expire = (vco_count == '0);
  // Test mode clocks the dividers straight from the reference
  assign vco_tick = test_mode ? ref_rise : vco_expire;
  assign locked = (stab_count == '0);

  always_comb begin
    next_fb_seen = fb_seen;
    next_trim = trim;
    next_feedback_early = feedback_early;
    next_vco_count = vco_count - 8'h01;
    next_stab_count = (stab_count == '0) ? stab_count
                                         : stab_count - 11'h001;
    if (restart) begin
      next_stab_count = STAB_WIDTH'(STAB_CYCLES);
    end
    if (fb_rise) begin
      next_fb_seen = 1'b1;
    end
    // Floating outputs break the loop, so trim only while driven
    if (ref_rise) begin
      next_fb_seen = 1'b0;
      if (output_enable_n || test_mode || fb_rise) begin
        next_trim = TRIM_NONE;
      end else if (fb_seen) begin
        next_trim = TRIM_LONGER;
        next_feedback_early = 1'b1;
      end else begin
        next_trim = TRIM_SHORTER;
        next_feedback_early = 1'b0;
      end
    end
    if (vco_expire) begin
      case (trim)
        TRIM_LONGER: next_vco_count = half_period;
        TRIM_SHORTER: next_vco_count = half_period - 8'h02;
        TRIM_NONE: next_vco_count = half_period - 8'h01;
        default: next_vco_count = half_period - 8'h01;
      endcase
      if (trim == TRIM_SHORTER && half_period < 8'h02) begin
        next_vco_count = '0;
      end
      // Keep a trim decided in this same cycle for the next expiry
      next_trim = ref_rise ? next_trim : TRIM_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_count <= '0;
      stab_count <= STAB_WIDTH'(STAB_CYCLES);
      fb_seen <= 1'b0;
      feedback_early <= 1'b0;
      trim <= TRIM_NONE;
    end else begin
      vco_count <= next_vco_count;
      stab_count <= next_stab_count;
      fb_seen <= next_fb_seen;
      feedback_early <= next_feedback_early;
      trim <= next_trim;
    end
  end

  assign status = '{feedback_early: feedback_early,
                    outputs_driven: ~output_enable_n,
                    bypass: test_mode,
                    locked: locked};

  // ==========================================================================
  // Divide by two and by four, with edge-triggered clear of the quarter stage
  logic half_q, quarter_q, half_carry, clear_pending, next_clear_pending;

  divide_by_two_stage half_stage (
    .pclk(pclk),
    .presetn(presetn),
    .tick(vco_tick),
    .realign(1'b0),
    .q(half_q),
    .carry(half_carry)
  );

  divide_by_two_stage quarter_stage (
    .pclk(pclk),
    .presetn(presetn),
    .tick(half_carry),
    .realign(clear_pending),
    .q(quarter_q),
    .carry()
  );

  // Clear waits for the half stage's falling edge, so no runt appears
  always_comb begin
    next_clear_pending = clear_fall | (clear_pending & ~half_carry);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_pending <= 1'b0;
    end else begin
      clear_pending <= next_clear_pending;
    end
  end

  // ==========================================================================
  // Bank steering and output enable
  logic [2:0] next_one, next_two, next_three, next_four;
  logic next_oe_n;

  always_comb begin
    next_one = {3{(sel_count >= 2'h1) ? quarter_q : half_q}};
    next_two = {3{(sel_count >= 2'h2) ? quarter_q : half_q}};
    next_three = {3{(sel_count == 2'h3) ? quarter_q : half_q}};
    next_four = {3{half_q}};
    next_oe_n = output_enable_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_one_clock_outs <= 3'h0;
      bank_two_clock_outs <= 3'h0;
      bank_three_clock_outs <= 3'h0;
      bank_four_clock_outs <= 3'h0;
      clock_outs_oe_n <= 1'b1;
    end else begin
      bank_one_clock_outs <= next_one;
      bank_two_clock_outs <= next_two;
      bank_three_clock_outs <= next_three;
      bank_four_clock_outs <= next_four;
      clock_outs_oe_n <= next_oe_n;
    end
  end

  // ==========================================================================
  // Checks
  // Cycles since the last restart, saturating, for the lock bound
  logic [STAB_WIDTH-1:0] wait_cycles, next_wait_cycles;

  always_comb begin
    next_wait_cycles = (wait_cycles == '1) ? wait_cycles
                                           : wait_cycles + 11'h001;
    if (restart) begin
      next_wait_cycles = 11'h001;
    end else if (locked) begin
      next_wait_cycles = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cycles <= 11'h001;
    end else begin
      wait_cycles <= next_wait_cycles;
    end
  end

  a_outputs_driven: assert property (
    @(posedge pclk) disable iff (!presetn)
    !output_enable_n |=> !clock_outs_oe_n)
    else $error("outputs not driven while enabled");

  a_outputs_floated: assert property (
    @(posedge pclk) disable iff (!presetn)
    output_enable_n |=> clock_outs_oe_n)
    else $error("outputs driven while disabled");

  a_unlock_after_restart: assert property (
    @(posedge pclk) disable iff (!presetn)
    restart |=> !locked [*8])
    else $error("lock reported inside stabilisation wait");

  a_lock_within_bound: assert property (
    @(posedge pclk) disable iff (!presetn)
    wait_cycles <= STAB_WIDTH'(STAB_CYCLES + 1))
    else $error("lock not reached within 50 us");

  a_clear_realigns: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_pending && half_carry |=> !quarter_q)
    else $error("quarter stage not cleared");

  a_half_no_runt: assert property (
    @(posedge pclk) disable iff (!presetn)
    !vco_tick |=> half_q == $past(half_q))
    else $error("half-rate clock moved without a tick");

  a_bypass_ticks: assert property (
    @(posedge pclk) disable iff (!presetn)
    test_mode && ref_rise |=> half_q != $past(half_q))
    else $error("bypass reference edge did not clock divider");

  a_pll_path_ticks: assert property (
    @(posedge pclk) disable iff (!presetn)
    !test_mode && vco_tick |-> vco_count == '0)
    else $error("tick outside VCO expiry in PLL mode");

  a_bank_four_half: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 bank_four_clock_outs == {3{$past(half_q)}})
    else $error("bank four not at half rate");

  a_bank_one_rate: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_count != 2'h0 |=> bank_one_clock_outs == {3{$past(quarter_q)}})
    else $error("bank one not at quarter rate");

  a_bank_three_rate: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_count != 2'h3 |=> bank_three_clock_outs == {3{$past(half_q)}})
    else $error("bank three not at half rate");

  a_trim_shortens: assert property (
    @(posedge pclk) disable iff (!presetn)
    ref_rise && !fb_seen && !fb_rise && !output_enable_n && !test_mode
      && !vco_expire |=> trim == TRIM_SHORTER)
    else $error("late feedback did not shorten VCO period");

endmodule : clock_fanout_control

`default_nettype wire

/* File: verilog/clock_fanout_pkg.sv */
// Constants, field layouts and carrier types for the PLL clock fanout control.
// Assumes one 20 MHz pclk and an APB master with 32-bit data.
// Function
// - Output enable low drives all twelve clock outputs.
// - Output enable high floats all twelve outputs, breaking the feedback path.
// - After output enable falls, outputs are unlocked during a stabilisation wait.
// - Falling edge on clear resets the quarter-rate divider; level is ignored.
// - Test low derives every output from the PLL path.
// - Test high bypasses the PLL, clocking dividers straight from the reference.
// - Banks one to three carry half or quarter VCO rate per selects.
// - Bank four always carries half the VCO rate.
// - Every output has a 50% duty cycle independent of the reference.
// - Loop trims VCO until feedback edges align with reference edges.
// - Selects set each bank's rate to equal, half or double the input; here they switch banks one to three between half and quarter VCO rate.
// - Input/output ratio follows selects and which output is fed back.
// - Select value 0..3 gives quarter rate to that many banks from one.
// - VCO divided by two and by four forms two 50% duty references.
// - Stabilisation after select change, enable fall or power-up is 50 us.
`default_nettype none

package clock_fanout_pkg;

  // ==========================================================================
  // Timing
  localparam int PCLK_MHZ = 20;
  localparam int STAB_TIME_US = 50;
  localparam int STAB_CYCLES = STAB_TIME_US * PCLK_MHZ;
  localparam int STAB_WIDTH = 11;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int PERIOD_WIDTH = 8;
  localparam logic [7:0] PERIOD_RESET = 8'h04;
  localparam logic [7:0] PERIOD_MIN = 8'h01;

  // Status word fields, low bits of the read data
  typedef struct packed {
    logic feedback_early;
    logic outputs_driven;
    logic bypass;
    logic locked;
  } status_type;

  // Phase trim applied to the next VCO half period
  typedef enum {TRIM_NONE, TRIM_LONGER, TRIM_SHORTER} trim_type;

endpackage : clock_fanout_pkg

`default_nettype wire

/* File: verilog/divide_by_two_stage.sv */
// One toggle stage of the VCO divider chain.
// Assumes tick is a one-cycle enable in the pclk domain.
`default_nettype none

module divide_by_two_stage (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic realign,
  output logic q,
  output logic carry
);

  logic next_q;

  // ==========================================================================
  // Toggle on each tick; realign forces the low phase instead of toggling
  always_comb begin
    next_q = q;
    if (tick) begin
      next_q = realign ? 1'b0 : ~q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // Next stage advances on the falling half of this one
  assign carry = tick & q;

endmodule : divide_by_two_stage

`default_nettype wire
